// [hw/tcbd_datapath.sv]
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module tcbd_datapath #(
  parameter int MS_CYCLES = tcbd_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register bus
  input wire tcbd_pkg::tcbd_apb_req_t apb_i,
  output tcbd_pkg::tcbd_apb_rsp_t apb_o,
  // transport pins
  input wire logic [11:0] xport_sw_i,
  input wire logic [8:0] rd_frame_i,
  input wire logic rd_stb_i,
  input wire logic mclr_code_i,
  output logic [8:0] nrzi_frame_o,
  output logic [8:0] pe_frame_o,
  output logic wr_stb_o,
  output logic [3:0] xport_sel_o,
  // sequencer flags
  output logic [1:0] tmr_flag_o,
  output logic mclr_irq_o
);

  if (MS_CYCLES < 2 || MS_CYCLES > 16383) begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end

  typedef struct packed {
    tcbd_pkg::tcbd_apb_rsp_t rsp;
    logic seven;
    logic pe;
    logic [1:0] mod_m1;
    logic legacy;
    logic [3:0] baddr;
    logic [7:0] obuf;
    logic obuf_pend;
    logic [31:0] oword;
    logic [1:0] ocount;
    logic ow_full;
    logic [21:0] fconv;
    logic [1:0][11:0] tcnt;
    logic [1:0] trun;
    logic [1:0] tflag;
    logic t2ms;
    logic [13:0] presc;
    logic [255:0][7:0] mem;
    logic [7:0] rptr;
    logic [7:0] wptr;
    logic [2:0] req_addr;
    logic [1:0] scan_idx;
    logic scan_busy;
    logic sel_valid;
    logic [1:0] sel_idx;
    logic [3:0] sel_oh;
    logic [11:0] sw_s1;
    logic [11:0] sw_s2;
    logic [8:0] fr_s1;
    logic [8:0] fr_s2;
    logic [2:0] rstb;
    logic [2:0] mclr;
    logic [8:0] frame_wr;
    logic wr_pend;
    logic [8:0] nrzi;
    logic [8:0] pe_fr;
    logic wr_stb;
    logic [8:0] frame_rd;
    logic frd_full;
    logic perr;
    logic mclr_irq;
  } tcbd_state_t;

  tcbd_state_t s;
  tcbd_state_t next_s;
  logic [8:0] scr_wr;
  logic [8:0] scr_rd;

  // ----------------------------------------------------------------
  // track scrambler, write and read sections
  // ----------------------------------------------------------------
  tcbd_scrambler u_scr_wr (
    .pass_i(s.seven), .restore_i(1'b0), .data_i(s.frame_wr), .data_o(scr_wr)
  );

  tcbd_scrambler u_scr_rd (
    .pass_i(s.seven), .restore_i(1'b1), .data_i(s.fr_s2), .data_o(scr_rd)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] rdv;
    logic [31:0] wd;
    logic [31:0] packed7;
    logic ws_empty;
    logic ws_full;
    logic [1:0] tick;
    logic [8:0] fr;
    access = apb_i.psel & apb_i.penable;
    wr = access & s.rsp.pready & apb_i.pwrite;
    rd = access & s.rsp.pready & ~apb_i.pwrite;
    mapped = 1'b1;
    rdv = 32'h0000_0000;
    wd = apb_i.pwdata;
    packed7 = 32'h0000_0000;
    ws_empty = (s.rptr == s.wptr);
    ws_full = ((s.wptr + 8'h01) == s.rptr);
    tick = 2'b00;
    fr = 9'h000;
    next_s = s;
    next_s.rsp.pready = 1'b0;
    next_s.wr_stb = 1'b0;

    // seven-track packing: byte k keeps six bits at 6k
    for (int k = 0; k < 4; k++) begin
      if (2'(k) <= s.mod_m1) begin
        packed7[6*k+:6] = s.oword[8*k+:6];
      end
    end

    unique case (apb_i.paddr)
      tcbd_pkg::A_CTRL: rdv = {26'h0, 1'b0, s.legacy, s.mod_m1, s.pe, s.seven};
      tcbd_pkg::A_BADDR: rdv = {28'h0, s.baddr};
      tcbd_pkg::A_OBUF: rdv = {24'h0, s.obuf};
      tcbd_pkg::A_OWORD: rdv = s.seven ? packed7 : s.oword;
      tcbd_pkg::A_FCONV: rdv = {10'h0, s.fconv};
      tcbd_pkg::A_TMR1: rdv = {19'h0, s.tflag[0], s.tcnt[0]};
      tcbd_pkg::A_TMR2: rdv = {18'h0, s.t2ms, s.tflag[1], s.tcnt[1]};
      tcbd_pkg::A_WSDATA: rdv = ws_empty ? 32'h0000_0000 :
        {23'h0, ~^s.mem[s.rptr], s.mem[s.rptr]};
      tcbd_pkg::A_STATUS: rdv = {20'h0, s.sel_idx, s.scan_busy, s.sel_valid, s.mclr_irq,
        s.perr, s.frd_full, s.tflag, s.ow_full, ws_full, ws_empty};
      tcbd_pkg::A_XPORT: rdv = {26'h0, s.sel_valid, s.sel_idx, s.req_addr};
      tcbd_pkg::A_FRWR: rdv = {23'h0, s.frame_wr};
      tcbd_pkg::A_FRRD: rdv = {21'h0, s.perr, s.frd_full, s.frame_rd};
      default: mapped = 1'b0;
    endcase

    if (access & ~s.rsp.pready) begin
      next_s.rsp.pready = 1'b1;
      next_s.rsp.pslverr = ~mapped;
      next_s.rsp.prdata = apb_i.pwrite ? 32'h0000_0000 : rdv;
    end

    // synchronisers
    next_s.sw_s1 = xport_sw_i;
    next_s.sw_s2 = s.sw_s1;
    next_s.fr_s1 = rd_frame_i;
    next_s.fr_s2 = s.fr_s1;
    next_s.rstb = {s.rstb[1:0], rd_stb_i};
    next_s.mclr = {s.mclr[1:0], mclr_code_i};

    // output byte buffer into word slot
    if (s.obuf_pend) begin
      next_s.obuf_pend = 1'b0;
      next_s.oword[8*s.baddr[1:0]+:8] = s.obuf;
      if (s.ocount == s.mod_m1) begin
        next_s.ocount = 2'b00;
        next_s.ow_full = 1'b1;
      end else begin
        next_s.ocount = s.ocount + 2'b01;
      end
    end
    if (rd && apb_i.paddr == tcbd_pkg::A_OWORD && !(s.obuf_pend && s.ocount == s.mod_m1)) begin
      next_s.ow_full = 1'b0;
    end

    // monitor timers
    tick[0] = 1'b1;
    tick[1] = s.t2ms ? (s.presc == 14'(MS_CYCLES - 1)) : 1'b1;
    next_s.presc = (s.presc == 14'(MS_CYCLES - 1)) ? 14'h0000 : s.presc + 14'h0001;
    for (int t = 0; t < 2; t++) begin
      if (s.trun[t] && tick[t]) begin
        next_s.tcnt[t] = s.tcnt[t] + 12'h001;
        if (s.tcnt[t] == tcbd_pkg::TMR_FULL - 12'h001) begin
          next_s.tflag[t] = 1'b1;
          next_s.trun[t] = 1'b0;
        end
      end
    end

    // transport scan
    if (s.scan_busy) begin
      if (s.sw_s2[3*s.scan_idx+:3] == s.req_addr) begin
        next_s.scan_busy = 1'b0;
        next_s.sel_valid = 1'b1;
        next_s.sel_idx = s.scan_idx;
        next_s.sel_oh = 4'h1 << s.scan_idx;
      end else if (s.scan_idx == 2'b11) begin
        next_s.scan_busy = 1'b0;
      end else begin
        next_s.scan_idx = s.scan_idx + 2'b01;
      end
    end

    // frame write path
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      next_s.wr_stb = 1'b1;
      if (s.pe && !s.seven) begin
        next_s.pe_fr = s.frame_wr;
      end else begin
        next_s.nrzi = scr_wr;
      end
    end

    // frame read path
    if (rd && apb_i.paddr == tcbd_pkg::A_FRRD) begin
      next_s.frd_full = 1'b0;
    end
    if (s.rstb[1] && !s.rstb[2]) begin
      fr = s.seven ? {2'b00, s.fr_s2[6:0]} : scr_rd;
      next_s.frame_rd = fr;
      next_s.frd_full = 1'b1;
      next_s.perr = ~(^fr);
    end

    // master clear in legacy mode
    if (wr && apb_i.paddr == tcbd_pkg::A_STATUS && wd[tcbd_pkg::S_MCLR]) begin
      next_s.mclr_irq = 1'b0;
    end
    if (s.legacy && s.mclr[1] && !s.mclr[2]) begin
      next_s.mclr_irq = 1'b1;
    end

    // working store fetch
    if (rd && apb_i.paddr == tcbd_pkg::A_WSDATA && !ws_empty) begin
      next_s.rptr = s.rptr + 8'h01;
    end

    // register writes
    if (wr) begin
      unique case (apb_i.paddr)
        tcbd_pkg::A_CTRL: begin
          next_s.seven = wd[tcbd_pkg::C_SEVEN];
          next_s.pe = wd[tcbd_pkg::C_PE];
          next_s.mod_m1 = wd[tcbd_pkg::C_MOD+:2];
          next_s.legacy = wd[tcbd_pkg::C_LEGACY];
          if (wd[tcbd_pkg::C_OPSTART]) begin
            next_s.rptr = 8'h00;
            next_s.wptr = 8'h00;
            next_s.ocount = 2'b00;
            next_s.ow_full = 1'b0;
          end
        end
        tcbd_pkg::A_BADDR: next_s.baddr = wd[3:0];
        tcbd_pkg::A_OBUF: begin
          next_s.obuf = wd[7:0];
          next_s.obuf_pend = 1'b1;
        end
        tcbd_pkg::A_FCONV: begin
          if (s.seven) begin
            if (wd[tcbd_pkg::F_DIR]) begin
              next_s.fconv = {16'h0000, wd[10:8], wd[2:0]};
            end else begin
              next_s.fconv = {2'b00, wd[5:3], wd[5:3], 2'b00, wd[2:0], wd[2:0], 6'h00};
            end
          end
        end
        tcbd_pkg::A_TMR1: begin
          next_s.tcnt[0] = wd[11:0];
          next_s.trun[0] = 1'b1;
          next_s.tflag[0] = 1'b0;
        end
        tcbd_pkg::A_TMR2: begin
          next_s.tcnt[1] = wd[11:0];
          next_s.trun[1] = 1'b1;
          next_s.tflag[1] = 1'b0;
          next_s.t2ms = wd[tcbd_pkg::T_MS];
        end
        tcbd_pkg::A_WSDATA: begin
          if (!ws_full) begin
            next_s.mem[s.wptr] = wd[7:0];
            next_s.wptr = s.wptr + 8'h01;
          end
        end
        tcbd_pkg::A_XPORT: begin
          next_s.req_addr = wd[2:0];
          next_s.scan_idx = 2'b00;
          next_s.scan_busy = 1'b1;
          next_s.sel_valid = 1'b0;
          next_s.sel_oh = 4'h0;
        end
        tcbd_pkg::A_FRWR: begin
          next_s.frame_wr = s.seven ? {2'b00, wd[6:0]} : wd[8:0];
          next_s.wr_pend = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign apb_o = s.rsp;
  assign nrzi_frame_o = s.nrzi;
  assign pe_frame_o = s.pe_fr;
  assign wr_stb_o = s.wr_stb;
  assign xport_sel_o = s.sel_oh;
  assign tmr_flag_o = s.tflag;
  assign mclr_irq_o = s.mclr_irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire logic wr_done = apb_i.psel & apb_i.penable & s.rsp.pready & apb_i.pwrite;
  wire logic rd_done = apb_i.psel & apb_i.penable & s.rsp.pready & ~apb_i.pwrite;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_OPSTART_CLEARS: assert property (
    wr_done && apb_i.paddr == tcbd_pkg::A_CTRL && apb_i.pwdata[tcbd_pkg::C_OPSTART]
    |=> s.rptr == 8'h00 && s.wptr == 8'h00)
    else $error("pointers not cleared at operation start");
  AST_WPTR_WRAP: assert property (
    wr_done && apb_i.paddr == tcbd_pkg::A_WSDATA && s.wptr == 8'hFF && s.rptr != 8'h00
    |=> s.wptr == 8'h00)
    else $error("write pointer did not wrap");
  AST_RPTR_STEP: assert property (
    rd_done && apb_i.paddr == tcbd_pkg::A_WSDATA && s.rptr != s.wptr
    |=> s.rptr == $past(s.rptr) + 8'h01)
    else $error("read pointer did not advance");
  AST_EMPTY_HOLD: assert property (
    rd_done && apb_i.paddr == tcbd_pkg::A_WSDATA && s.rptr == s.wptr |=> $stable(s.rptr))
    else $error("fetch from empty store moved pointer");
  AST_FETCH_PARITY: assert property (
    s.rsp.pready && !apb_i.pwrite && apb_i.paddr == tcbd_pkg::A_WSDATA && s.rptr != s.wptr
    |-> ^s.rsp.prdata[8:0])
    else $error("fetched word has wrong parity");
  AST_TMR_FLAG: assert property (
    s.trun[0] && s.tcnt[0] == 12'hFFE && !wr_done |=> s.tflag[0] && s.tcnt[0] == 12'hFFF)
    else $error("timer one flag missing at capacity");
  AST_TMR_IDLE: assert property (
    !s.trun[1] && !wr_done |=> $stable(s.tcnt[1]))
    else $error("timer two counted without preset");
  AST_SLOT_FILL: assert property (
    s.obuf_pend |=> s.oword[8*$past(s.baddr[1:0])+:8] == $past(s.obuf))
    else $error("byte not placed at addressed slot");
  AST_SEVEN_PASS: assert property (
    s.wr_pend && s.seven && !s.pe |=> s.nrzi == s.frame_wr && s.wr_stb)
    else $error("seven-track frame was reordered");
  AST_FCONV_EXP: assert property (
    wr_done && apb_i.paddr == tcbd_pkg::A_FCONV && s.seven && !apb_i.pwdata[tcbd_pkg::F_DIR]
    |=> s.fconv[11:6] == {2{$past(apb_i.pwdata[2:0])}})
    else $error("format converter expansion wrong");

  COV_WORD_FULL: cover property (s.obuf_pend ##1 s.ow_full);
  COV_TMR_FLAG: cover property (s.trun[1] ##1 s.tflag[1]);
  COV_XPORT_SEL: cover property (s.scan_busy ##[1:4] s.sel_valid);
  COV_MCLR: cover property (s.legacy ##[1:8] s.mclr_irq);

endmodule : tcbd_datapath

// [hw/tcbd_pkg.sv]
// Functional notes
// - bytes per word follow the configured modulus
// - byte position picks the receiving word slot
// - buffer to word moves a whole byte
// - seven-track bytes use low six bits
// - seven-track readout packs bytes six bits apart
// - converter works only in seven-track mode
// - write expands byte into two mirrored halves
// - read joins two frames into one byte
// - four-bit byte position register, read and write
// - two twelve-stage timers count after preset
// - timer at capacity raises a sampled flag
// - timer two selects fast or millisecond rate
// - working store fifo holds 255 of its 256 bytes
// - pointers wrap from 255 to zero
// - operation start clears both store pointers
// - pointers advance per store and fetch
// - fetched word gets its parity bit
// - scan switches, select the matching transport
// - frame write register feeds nrzi or pe
// - frame read register holds, checks parity
// - nine-track nrzi scrambles, seven-track passes
// - legacy mode flags master clear only
// - output byte buffer holds bus byte
package tcbd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BADDR = 8'h04;
  localparam logic [7:0] A_OBUF = 8'h08;
  localparam logic [7:0] A_OWORD = 8'h0C;
  localparam logic [7:0] A_FCONV = 8'h10;
  localparam logic [7:0] A_TMR1 = 8'h14;
  localparam logic [7:0] A_TMR2 = 8'h18;
  localparam logic [7:0] A_WSDATA = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_XPORT = 8'h24;
  localparam logic [7:0] A_FRWR = 8'h28;
  localparam logic [7:0] A_FRRD = 8'h2C;

  // ctrl fields
  localparam int C_SEVEN = 0;
  localparam int C_PE = 1;
  localparam int C_MOD = 2;
  localparam int C_LEGACY = 4;
  localparam int C_OPSTART = 8;
  // format converter direction bit in write data
  localparam int F_DIR = 16;
  // timer two rate select bit in write data
  localparam int T_MS = 12;
  // status clear bit for master clear flag
  localparam int S_MCLR = 7;

  localparam logic [11:0] TMR_FULL = 12'hFFF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // nine-track bit order: output bit i takes input bit PERM[4i+:4]
  localparam logic [35:0] PERM = 36'h753102468;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tcbd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tcbd_apb_rsp_t;

endpackage : tcbd_pkg

// [hw/tcbd_scrambler.sv]
`timescale 1ns/1ns
module tcbd_scrambler #(
  parameter logic [35:0] PERM = tcbd_pkg::PERM
) (
  // control
  input wire logic pass_i,
  input wire logic restore_i,
  // data
  input wire logic [8:0] data_i,
  output logic [8:0] data_o
);

  logic [8:0] fwd;
  logic [8:0] inv;

  // ----------------------------------------------------------------
  // per-bit reorder and its inverse
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 9; i++) begin : g_bit
    if (PERM[4*i+:4] > 4'h8) begin : g_bad
      $error("scrambler index out of range");
    end
    assign fwd[i] = data_i[PERM[4*i+:4]];
    assign inv[PERM[4*i+:4]] = data_i[i];
  end

  assign data_o = pass_i ? data_i : (restore_i ? inv : fwd);

endmodule : tcbd_scrambler

// [verification/tcbd_xport_model.sv]
`timescale 1ns/1ns
module tcbd_xport_model #(
  parameter logic [11:0] SW = 12'hABC
) (
  // clock
  input wire logic clk_sys_i,
  // write side
  input wire logic [8:0] nrzi_frame_i,
  input wire logic [8:0] pe_frame_i,
  input wire logic wr_stb_i,
  // read side and panel
  output logic [11:0] xport_sw_o,
  output logic [8:0] rd_frame_o,
  output logic rd_stb_o,
  output logic mclr_code_o
);
  logic [8:0] last_nrzi = 9'h000;
  logic [8:0] last_pe = 9'h000;
  int n_stb = 0;

  // panel switches: transport k answers to SW[3k+2:3k]
  assign xport_sw_o = SW;

  initial begin
    rd_frame_o = 9'h000;
    rd_stb_o = 1'b0;
    mclr_code_o = 1'b0;
  end

  // recorder: keeps the frame offered with each write strobe
  always @(posedge clk_sys_i) begin
    if (wr_stb_i === 1'b1) begin
      last_nrzi <= nrzi_frame_i;
      last_pe <= pe_frame_i;
      n_stb <= n_stb + 1;
    end
  end

  // head output: frame steady around the strobe, inverted level after
  task automatic send_frame(input logic [8:0] f);
    @(posedge clk_sys_i);
    rd_frame_o <= f;
    @(posedge clk_sys_i);
    rd_stb_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd_stb_o <= 1'b0;
    rd_frame_o <= ~f;
  endtask : send_frame

  task automatic pulse_mclr;
    @(posedge clk_sys_i);
    mclr_code_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    mclr_code_o <= 1'b0;
  endtask : pulse_mclr
endmodule : tcbd_xport_model

// [verification/test_tape_ctrl_byte_datapath.sv]
`timescale 1ns/1ns
module test_tape_ctrl_byte_datapath;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  tcbd_pkg::tcbd_apb_req_t apb_i = '0;
  tcbd_pkg::tcbd_apb_rsp_t apb_o;
  logic [11:0] xport_sw;
  logic [8:0] rd_frame, nrzi_frame, pe_frame;
  logic rd_stb, mclr_code, wr_stb, mclr_irq;
  logic [3:0] xport_sel;
  logic [1:0] tmr_flag;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  tcbd_datapath #(.MS_CYCLES(4)) DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o),
    .xport_sw_i(xport_sw), .rd_frame_i(rd_frame), .rd_stb_i(rd_stb),
    .mclr_code_i(mclr_code), .nrzi_frame_o(nrzi_frame), .pe_frame_o(pe_frame),
    .wr_stb_o(wr_stb), .xport_sel_o(xport_sel), .tmr_flag_o(tmr_flag),
    .mclr_irq_o(mclr_irq)
  );

  tcbd_xport_model XP (
    .clk_sys_i(clk_sys_i), .nrzi_frame_i(nrzi_frame), .pe_frame_i(pe_frame),
    .wr_stb_i(wr_stb), .xport_sw_o(xport_sw), .rd_frame_o(rd_frame),
    .rd_stb_o(rd_stb), .mclr_code_o(mclr_code)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    checks_done++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (apb_o.pready !== 1'b1);
    q = apb_o.prdata;
    e = apb_o.pslverr;
    chk("wait states", 32'h2, n);
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask : xfer

  function automatic logic [8:0] scr(input logic [8:0] d);
    for (int i = 0; i < 9; i++) begin
      scr[i] = d[tcbd_pkg::PERM[4*i+:4]];
    end
  endfunction : scr

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    xfer(0, tcbd_pkg::A_STATUS, 0);
    chk("status reset", 32'h1, q);
    xfer(0, tcbd_pkg::A_TMR1, 0);
    chk("timer idle", 32'h0, q);
    xfer(0, 8'h3C, 0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    xfer(1, tcbd_pkg::A_BADDR, 32'hFFFFFFFF);
    xfer(0, tcbd_pkg::A_BADDR, 0);
    chk("byte position", 32'hF, q);
    $display("reset test done");
    xfer(1, tcbd_pkg::A_CTRL, 32'h10C);
    for (int k = 0; k < 4; k++) begin
      xfer(1, tcbd_pkg::A_BADDR, 3 - k);
      xfer(1, tcbd_pkg::A_OBUF, 8'hA1 + k * 8'h11);
    end
    xfer(0, tcbd_pkg::A_STATUS, 0);
    chk("word full", 32'h1, {31'h0, q[2]});
    xfer(0, tcbd_pkg::A_OWORD, 0);
    chk("word nine", 32'hA1B2C3D4, q);
    xfer(1, tcbd_pkg::A_CTRL, 32'h109);
    for (int k = 0; k < 3; k++) begin
      xfer(0, tcbd_pkg::A_STATUS, 0);
      chk("word part", 32'h0, {31'h0, q[2]});
      xfer(1, tcbd_pkg::A_BADDR, k);
      xfer(1, tcbd_pkg::A_OBUF, k == 0 ? 8'hC5 : k == 1 ? 8'hFA : 8'h3B);
    end
    xfer(0, tcbd_pkg::A_OWORD, 0);
    chk("word seven", 32'h3BE85, q);
    $display("word test done");
    xfer(1, tcbd_pkg::A_CTRL, 32'h101);
    xfer(1, tcbd_pkg::A_FCONV, 32'h2B);
    xfer(0, tcbd_pkg::A_FCONV, 0);
    chk("expand", 32'h2D1B, {16'h0, q[21:6]});
    xfer(1, tcbd_pkg::A_FCONV, 32'h12D1B);
    xfer(0, tcbd_pkg::A_FCONV, 0);
    chk("join", 32'h2B, {26'h0, q[5:0]});
    xfer(1, tcbd_pkg::A_CTRL, 32'h100);
    xfer(1, tcbd_pkg::A_FCONV, 32'h1003F);
    xfer(0, tcbd_pkg::A_FCONV, 0);
    chk("conv nine", 32'h2B, {26'h0, q[5:0]});
    $display("converter test done");
    xfer(1, tcbd_pkg::A_TMR1, 32'hFFD);
    xfer(0, tcbd_pkg::A_TMR1, 0);
    chk("timer1", 32'h1FFF, q);
    chk("flag1", 32'h1, {31'h0, tmr_flag[0]});
    xfer(1, tcbd_pkg::A_TMR2, 32'hFFE);
    xfer(0, tcbd_pkg::A_TMR2, 0);
    chk("timer2 fast", 32'h1FFF, q);
    xfer(1, tcbd_pkg::A_TMR2, 32'h1FFC);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("flag2 slow", 32'h0, {31'h0, tmr_flag[1]});
    repeat (20) @(posedge clk_sys_i);
    xfer(0, tcbd_pkg::A_TMR2, 0);
    chk("timer2 slow", 32'h3FFF, q);
    $display("timer test done");
    xfer(1, tcbd_pkg::A_WSDATA, 32'h77);
    xfer(1, tcbd_pkg::A_CTRL, 32'h100);
    xfer(0, tcbd_pkg::A_STATUS, 0);
    chk("store cleared", 32'h1, {30'h0, q[1:0]});
    for (int i = 0; i < 256; i++) begin
      xfer(1, tcbd_pkg::A_WSDATA, i);
    end
    xfer(0, tcbd_pkg::A_STATUS, 0);
    chk("store full", 32'h2, {30'h0, q[1:0]});
    for (int i = 0; i < 255; i++) begin
      xfer(0, tcbd_pkg::A_WSDATA, 0);
      chk("store data", {~^i[7:0], i[7:0]}, q[8:0]);
    end
    xfer(0, tcbd_pkg::A_WSDATA, 0);
    chk("store empty", 32'h0, q);
    xfer(1, tcbd_pkg::A_WSDATA, 32'h5A);
    xfer(1, tcbd_pkg::A_WSDATA, 32'hC3);
    xfer(0, tcbd_pkg::A_WSDATA, 0);
    chk("wrap a", 32'h15A, q);
    xfer(0, tcbd_pkg::A_WSDATA, 0);
    chk("wrap b", 32'h1C3, q);
    $display("store test done");
    xfer(1, tcbd_pkg::A_XPORT, 32'h2);
    repeat (3) xfer(0, tcbd_pkg::A_STATUS, 0);
    chk("select pins", 32'h4, {28'h0, xport_sel});
    xfer(0, tcbd_pkg::A_XPORT, 0);
    chk("select reg", 32'h32, q);
    xfer(1, tcbd_pkg::A_XPORT, 32'h3);
    repeat (3) xfer(0, tcbd_pkg::A_STATUS, 0);
    chk("no match", 32'h0, {28'h0, xport_sel});
    $display("select test done");
    xfer(1, tcbd_pkg::A_FRWR, 32'h1A5);
    repeat (4) @(posedge clk_sys_i);
    chk("nrzi nine", scr(9'h1A5), XP.last_nrzi);
    xfer(1, tcbd_pkg::A_CTRL, 32'h102);
    xfer(1, tcbd_pkg::A_FRWR, 32'h1A5);
    repeat (4) @(posedge clk_sys_i);
    chk("pe nine", 32'h1A5, XP.last_pe);
    xfer(1, tcbd_pkg::A_CTRL, 32'h101);
    xfer(1, tcbd_pkg::A_FRWR, 32'h1A5);
    repeat (4) @(posedge clk_sys_i);
    chk("nrzi seven", 32'h25, XP.last_nrzi);
    chk("strobes", 32'h3, XP.n_stb);
    XP.send_frame(9'h25);
    xfer(0, tcbd_pkg::A_FRRD, 0);
    chk("read seven", 32'h225, q);
    xfer(1, tcbd_pkg::A_CTRL, 32'h100);
    XP.send_frame(scr(9'h1A5));
    xfer(0, tcbd_pkg::A_FRRD, 0);
    chk("read nine", 32'h3A5, q);
    xfer(0, tcbd_pkg::A_FRRD, 0);
    chk("read taken", 32'h1A5, q);
    XP.send_frame(scr(9'h1A4));
    xfer(0, tcbd_pkg::A_FRRD, 0);
    chk("read parity", 32'h7A4, q);
    $display("frame test done");
    XP.pulse_mclr();
    repeat (8) @(posedge clk_sys_i);
    chk("mclr off", 32'h0, {31'h0, mclr_irq});
    xfer(1, tcbd_pkg::A_CTRL, 32'h110);
    xfer(0, tcbd_pkg::A_CTRL, 0);
    chk("ctrl readback", 32'h10, q);
    XP.pulse_mclr();
    repeat (8) @(posedge clk_sys_i);
    chk("mclr on", 32'h1, {31'h0, mclr_irq});
    xfer(1, tcbd_pkg::A_STATUS, 32'h80);
    @(negedge clk_sys_i);
    chk("mclr clear", 32'h0, {31'h0, mclr_irq});
    $display("clear test done");
    give_verdict();
  end
endmodule : test_tape_ctrl_byte_datapath
